// ==== common/cfs_pkg.sv ====
package cfs_pkg;
  // ==========================================
  // register indices and byte addresses
  localparam logic [9:0]  IDX_SYNTH   = 10'h004;
  localparam logic [9:0]  IDX_SYNTH_OUTPUT_DIVIDER = 10'h006;
  localparam logic [9:0]  IDX_FLAGS   = 10'h007;
  localparam logic [9:0]  IDX_ENABLE  = 10'h008;
  localparam logic [9:0]  IDX_CLKSEL  = 10'h009;
  localparam logic [11:0] ADDR_SYNTH   = {IDX_SYNTH, 2'b00};
  localparam logic [11:0] ADDR_SYNTH_OUTPUT_DIVIDER = {IDX_SYNTH_OUTPUT_DIVIDER, 2'b00};
  localparam logic [11:0] ADDR_FLAGS   = {IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_ENABLE  = {IDX_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_CLKSEL  = {IDX_CLKSEL, 2'b00};
  // ==========================================
  // flag and enable bit positions
  localparam int B_TICK = 7;
  localparam int B_LCHG = 4;
  localparam int B_LOCK = 3;
  localparam int B_OCHG = 1;
  localparam int B_QUAL = 0;
  // ==========================================
  // clock-select bit positions
  localparam int B_SYSTEM_CLOCK_FROM_SYNTH = 7;
  localparam int B_KEEP   = 6;
  localparam int B_WDHALT = 5;
  localparam int B_WDHI   = 4;
  localparam int B_TKPS   = 3;
  localparam int B_WDPS   = 2;
  localparam int B_TKSRC  = 1;
  localparam int B_WDLO   = 0;
  // fields writable in normal mode while the guard is off
  localparam logic [7:0] MASK_NORMAL = 8'hce;
  // fields writable until watchdog write-once
  localparam logic [7:0] MASK_WDOG   = 8'h31;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_CLKSEL  = 8'h80;
  localparam logic [7:0] RST_SYNTH   = 8'h00;
  localparam logic [4:0] RST_SYNTH_OUTPUT_DIVIDER = 5'h03;
  // ==========================================
  // divide ratio while unlocked
  localparam logic [5:0] DIV_UNLOCKED = 6'h04;
endpackage : cfs_pkg

// ==== rtl/cfs_clock_flags.sv ====
`timescale 1ns/10ps
module cfs_clock_flags
  import cfs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // events and status from the clock core
  input  wire logic        tick_timeout_i,
  input  wire logic        pll_lock_i,
  input  wire logic        osc_good_i,
  input  wire logic        full_stop_entry_i,
  input  wire logic        osc_loss_i,
  // mode and protection
  input  wire logic        write_guard_bit_i,
  input  wire logic        special_mode_i,
  input  wire logic        watchdog_written_once_i,
  input  wire logic        osc_monitor_reset_enable_i,
  // requests and clock control
  output logic             tick_irq_o,
  output logic             pll_state_change_irq_o,
  output logic             osc_change_irq_o,
  output logic      [7:0]  clock_source_select_o,
  output logic      [5:0]  synth_clock_divide_o,
  output logic             system_stall_o
);

  // ==========================================
  // state
  logic [2:0]  flag_reg;     // tick, lock change, osc change
  logic [2:0]  flag_next;
  logic [2:0]  en_reg;       // matching enables
  logic [2:0]  en_next;
  logic        lock_reg;     // lock status
  logic        lock_next;
  logic        qual_reg;     // oscillator qualified status
  logic        qual_next;
  logic        reopen_reg;   // select lo may be set again
  logic        reopen_next;
  logic [7:0]  clks_reg;     // clock source select
  logic [7:0]  clks_next;
  logic [7:0]  synth_reg;    // synthesizer multiplier
  logic [4:0]  synth_output_divider_reg;  // synthesizer output divider
  logic [2:0]  irq_reg;      // registered requests
  logic [5:0]  div_reg;      // registered divide ratio
  logic [5:0]  div_next;
  logic        stall_reg;    // registered stall
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // ==========================================
  // apb decode
  wire access_w  = psel_i & penable_i;
  // one wait state: the answer edge is the commit edge
  wire commit_w  = access_w & pready_reg;
  wire wr_w      = commit_w & pwrite_i;
  wire hit_syn   = (paddr_i == ADDR_SYNTH);
  wire hit_pdv   = (paddr_i == ADDR_SYNTH_OUTPUT_DIVIDER);
  wire hit_flg   = (paddr_i == ADDR_FLAGS);
  wire hit_en    = (paddr_i == ADDR_ENABLE);
  wire hit_clk   = (paddr_i == ADDR_CLKSEL);
  wire mapped_w  = hit_syn | hit_pdv | hit_flg | hit_en | hit_clk;
  wire [7:0] wd8 = pwdata_i[7:0];

  // ==========================================
  // write qualifiers
  // synthesizer needs guard off and synth clock selected
  wire syn_wr_w  = wr_w & hit_syn & ~write_guard_bit_i & clks_reg[B_SYSTEM_CLOCK_FROM_SYNTH];
  // output divider needs synth clock selected
  wire pdv_wr_w  = wr_w & hit_pdv & clks_reg[B_SYSTEM_CLOCK_FROM_SYNTH];
  wire flg_wr_w  = wr_w & hit_flg;
  wire en_wr_w   = wr_w & hit_en;
  // guard blocks clock-select in every mode
  wire clk_wr_w  = wr_w & hit_clk & ~write_guard_bit_i;

  // ==========================================
  // status tracking
  // a synthesizer write restarts both qualifications
  assign lock_next = syn_wr_w ? 1'b0 : pll_lock_i;
  // full stop also drops qualification
  assign qual_next = (syn_wr_w | full_stop_entry_i) ? 1'b0 : osc_good_i;
  wire qual_fall_w = qual_reg & ~qual_next;

  // ==========================================
  // event flags, set beats write-one clear
  wire [2:0] set_w = {tick_timeout_i,
                      lock_reg ^ lock_next,
                      qual_reg ^ qual_next};
  wire [2:0] clr_w = flg_wr_w ? {wd8[B_TICK], wd8[B_LCHG], wd8[B_OCHG]}
                              : 3'h0;
  assign flag_next = set_w | (flag_reg & ~clr_w);
  assign en_next   = en_wr_w ? {wd8[B_TICK], wd8[B_LCHG], wd8[B_OCHG]}
                             : en_reg;

  // ==========================================
  // clock-select write masking
  // special mode opens every bit
  wire [7:0] wd_open_w = watchdog_written_once_i ? 8'h00 : MASK_WDOG;
  // reopened select lo may only be set, not cleared
  wire reopen_set_w = reopen_reg & wd8[B_WDLO];
  wire [7:0] mask_w = special_mode_i ? 8'hff
                    : (MASK_NORMAL | wd_open_w
                       | {7'h00, reopen_set_w});
  wire [7:0] eff_mask_w = clk_wr_w ? mask_w : 8'h00;
  wire [7:0] merged_w   = (clks_reg & ~eff_mask_w) | (wd8 & eff_mask_w);

  // ==========================================
  // automatic changes to clock select
  always_comb begin
    clks_next = merged_w;
    // select lo drops when qualification falls
    if (qual_fall_w) begin
      clks_next[B_WDLO] = 1'b0;
    end
    // select hi is left alone here on purpose
    // synth clock forced while unqualified
    if (!qual_next || full_stop_entry_i) begin
      clks_next[B_SYSTEM_CLOCK_FROM_SYNTH] = 1'b1;
    end
  end

  // ==========================================
  // reopen bookkeeping for select lo
  always_comb begin
    reopen_next = reopen_reg;
    // armed only when the auto clear took a set bit
    if (qual_fall_w && clks_reg[B_WDLO]) begin
      reopen_next = 1'b1;
    end else if (clk_wr_w && reopen_set_w) begin
      reopen_next = 1'b0;
    end
  end

  // ==========================================
  // synthesizer divide ratio
  wire [5:0] pdv_plus_w = {1'b0, synth_output_divider_reg} + 6'h01;
  assign div_next = lock_reg ? pdv_plus_w : DIV_UNLOCKED;

  // ==========================================
  // read mux
  wire [7:0] flags_rd_w = {flag_reg[2], 2'b00, flag_reg[1], lock_reg,
                           1'b0, flag_reg[0], qual_reg};
  wire [7:0] en_rd_w    = {en_reg[2], 2'b00, en_reg[1], 2'b00, en_reg[0], 1'b0};
  wire [7:0] rd8_w = hit_syn ? synth_reg
                   : hit_pdv ? {3'h0, synth_output_divider_reg}
                   : hit_flg ? flags_rd_w
                   : hit_en  ? en_rd_w
                   : hit_clk ? clks_reg
                   : 8'h00;

  // ==========================================
  // apb handshake
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      // ready for one cycle, one edge after access starts
      pready_reg  <= access_w & ~pready_reg;
      pslverr_reg <= access_w & ~pready_reg & ~mapped_w;
      // data only valid beside ready
      prdata_reg  <= (access_w & ~pready_reg) ? {24'h0, rd8_w} : 32'h0;
    end
  end

  // ==========================================
  // flag, enable and status registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg   <= 3'h0;
      en_reg     <= 3'h0;
      lock_reg   <= 1'b0;
      qual_reg   <= 1'b0;
      reopen_reg <= 1'b0;
    end else begin
      flag_reg   <= flag_next;
      en_reg     <= en_next;
      lock_reg   <= lock_next;
      qual_reg   <= qual_next;
      reopen_reg <= reopen_next;
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clks_reg    <= RST_CLKSEL;
      synth_reg   <= RST_SYNTH;
      synth_output_divider_reg <= RST_SYNTH_OUTPUT_DIVIDER;
    end else begin
      clks_reg <= clks_next;
      if (syn_wr_w) begin
        synth_reg <= wd8;
      end
      if (pdv_wr_w) begin
        synth_output_divider_reg <= wd8[4:0];
      end
    end
  end

  // ==========================================
  // requests and control outputs
  // requests track flag and enable of the same edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_reg   <= 3'h0;
      div_reg   <= DIV_UNLOCKED;
      stall_reg <= 1'b0;
    end else begin
      irq_reg   <= flag_next & en_next;
      div_reg   <= div_next;
      // no monitor reset means the core just waits
      stall_reg <= ~clks_next[B_SYSTEM_CLOCK_FROM_SYNTH] & ~osc_monitor_reset_enable_i
                   & osc_loss_i;
    end
  end

  // ==========================================
  // output wiring
  assign prdata_o               = prdata_reg;
  assign pready_o               = pready_reg;
  assign pslverr_o              = pslverr_reg;
  assign tick_irq_o             = irq_reg[2];
  assign pll_state_change_irq_o = irq_reg[1];
  assign osc_change_irq_o       = irq_reg[0];
  assign clock_source_select_o  = clks_reg;
  assign synth_clock_divide_o   = div_reg;
  assign system_stall_o         = stall_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_tick_set;
    tick_timeout_i |=> flag_reg[2] ##1 (flag_reg[2] || $past(flg_wr_w));
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("tick flag not set");

  property p_tick_irq;
    tick_timeout_i && en_next[2] |=> tick_irq_o;
  endproperty
  a_tick_irq: assert property (p_tick_irq) else $error("tick request missing");

  property p_lock_flag;
    $changed(lock_reg) |-> flag_reg[1] && (pll_state_change_irq_o == en_reg[1]);
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock change lost");

  property p_irq_and;
    {tick_irq_o, pll_state_change_irq_o, osc_change_irq_o} == (flag_reg & en_reg);
  endproperty
  a_irq_and: assert property (p_irq_and) else $error("request not flag and enable");

  property p_osc_flag;
    $changed(qual_reg) |-> flag_reg[0] && (osc_change_irq_o == en_reg[0]);
  endproperty
  a_osc_flag: assert property (p_osc_flag) else $error("osc change lost");

  property p_divide;
    synth_clock_divide_o == ($past(lock_reg) ? $past(pdv_plus_w) : DIV_UNLOCKED);
  endproperty
  a_divide: assert property (p_divide) else $error("divide ratio wrong");

  property p_full_stop;
    full_stop_entry_i |=> !qual_reg && clks_reg[B_SYSTEM_CLOCK_FROM_SYNTH];
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("full stop not honoured");

  property p_guard;
    clk_wr_w == 1'b0 && wr_w && hit_clk && qual_reg && qual_next
      && !full_stop_entry_i |=> $stable(clks_reg);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write took");

  property p_unqual_sel;
    !qual_reg |-> clks_reg[B_SYSTEM_CLOCK_FROM_SYNTH];
  endproperty
  a_unqual_sel: assert property (p_unqual_sel) else $error("synth select not forced");

  property p_synth_clear;
    syn_wr_w |=> !lock_reg && !qual_reg;
  endproperty
  a_synth_clear: assert property (p_synth_clear) else $error("synth write kept status");

  property p_apb_ready;
    access_w && !pready_reg |=> pready_reg ##1 !pready_reg;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

  c_tick_irq:  cover property (tick_timeout_i && en_reg[2] ##1 tick_irq_o);
  c_lock_both: cover property (lock_reg ##[1:20] !lock_reg);
  c_reopen:    cover property (reopen_reg ##[1:20] clks_reg[B_WDLO]);
  c_stall:     cover property (system_stall_o);

endmodule : cfs_clock_flags

// ==== test/clock_unit_flags_and_select_bench.sv ====
`timescale 1ns/10ps
module clock_unit_flags_and_select_bench
  import cfs_pkg::*;
;
  // ==========================================
  // bench signals
  logic        ref_clk_i = 1'b0;  // bus clock
  logic        resetn_i  = 1'b0;  // async reset, low active
  logic        psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;           // byte address
  logic [31:0] pwdata_i;          // write data, byte in 7:0
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  logic        tick_timeout_i, pll_lock_i, osc_good_i, full_stop_entry_i, osc_loss_i;
  logic        write_guard_bit_i, special_mode_i, watchdog_written_once_i;
  logic        osc_monitor_reset_enable_i;
  logic        tick_irq_o, pll_state_change_irq_o, osc_change_irq_o, system_stall_o;
  logic [7:0]  clock_source_select_o;
  logic [5:0]  synth_clock_divide_o;
  int          fail_count  = 0;   // mismatches seen
  int          check_count = 0;   // comparisons made
  logic [7:0]  sel_exp;           // modelled clock-select contents
  logic [7:0]  rnd;               // random byte
  logic [7:0]  rv;                // read value
  logic        er;                // response error
  // ==========================================
  // clock and device
  always #5 ref_clk_i = ~ref_clk_i;
  cfs_clock_flags u_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .tick_timeout_i(tick_timeout_i),
    .pll_lock_i(pll_lock_i), .osc_good_i(osc_good_i), .full_stop_entry_i(full_stop_entry_i),
    .osc_loss_i(osc_loss_i), .write_guard_bit_i(write_guard_bit_i),
    .special_mode_i(special_mode_i), .watchdog_written_once_i(watchdog_written_once_i),
    .osc_monitor_reset_enable_i(osc_monitor_reset_enable_i), .tick_irq_o(tick_irq_o),
    .pll_state_change_irq_o(pll_state_change_irq_o), .osc_change_irq_o(osc_change_irq_o),
    .clock_source_select_o(clock_source_select_o),
    .synth_clock_divide_o(synth_clock_divide_o), .system_stall_o(system_stall_o));
  // ==========================================
  // compare and verdict
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // ==========================================
  // apb master: hold request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h000000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    // bounded wait, the slave decides how many wait states
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (n >= 16) begin
      fail_count++;
    end
    r = prdata_o[7:0];
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, a, 8'h00, r, e);
    chk8(r, exp);
  endtask : rd_chk
  // let n edges land, then look between edges
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : wait_n
  // expected clock-select after a write; qualified oscillator assumed
  function automatic logic [7:0] sel_next(input logic [7:0] old, input logic [7:0] d,
                                          input logic g, input logic s, input logic o);
    if (g) return old;
    if (s || !o) return d;
    return (d & MASK_NORMAL) | (old & MASK_WDOG);
  endfunction : sel_next
  // ==========================================
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    fail_count++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, tick_timeout_i, pll_lock_i, osc_good_i} = '0;
    {full_stop_entry_i, osc_loss_i, write_guard_bit_i, special_mode_i} = '0;
    {watchdog_written_once_i, osc_monitor_reset_enable_i} = '0;
    paddr_i  = 12'h000;
    pwdata_i = 32'h00000000;
    void'($urandom(32'h035baa5f));
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    wait_n(1);
    chk8(clock_source_select_o, RST_CLKSEL);
    chk8({2'b00, synth_clock_divide_o}, {2'b00, DIV_UNLOCKED});
    // tick event: flag, write-zero keeps, enable gates, write-one clears
    @(posedge ref_clk_i) tick_timeout_i <= 1'b1;
    @(posedge ref_clk_i) tick_timeout_i <= 1'b0;
    wait_n(1);
    chk1(tick_irq_o, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h80);
    wr(ADDR_ENABLE, 8'h80);
    wait_n(1);
    chk1(tick_irq_o, 1'b1);
    wr(ADDR_FLAGS, 8'h80);
    wait_n(1);
    chk1(tick_irq_o, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h00);
    // lock change both ways, read-only status, divide ratio
    @(posedge ref_clk_i) pll_lock_i <= 1'b1;
    wait_n(3);
    wr(ADDR_FLAGS, 8'h08);
    rd_chk(ADDR_FLAGS, 8'h18);
    wr(ADDR_SYNTH_OUTPUT_DIVIDER, 8'h07);
    wait_n(2);
    chk8({2'b00, synth_clock_divide_o}, 8'h08);
    wr(ADDR_ENABLE, 8'h10);
    wait_n(1);
    chk1(pll_state_change_irq_o, 1'b1);
    wr(ADDR_FLAGS, 8'h10);
    rd_chk(ADDR_FLAGS, 8'h08);
    @(posedge ref_clk_i) pll_lock_i <= 1'b0;
    wait_n(3);
    chk1(pll_state_change_irq_o, 1'b1);
    chk8({2'b00, synth_clock_divide_o}, {2'b00, DIV_UNLOCKED});
    wr(ADDR_FLAGS, 8'h10);
    // oscillator qualification change
    @(posedge ref_clk_i) osc_good_i <= 1'b1;
    wait_n(3);
    wr(ADDR_ENABLE, 8'h02);
    wait_n(1);
    chk1(osc_change_irq_o, 1'b1);
    wr(ADDR_FLAGS, 8'h01);
    rd_chk(ADDR_FLAGS, 8'h03);
    wr(ADDR_FLAGS, 8'h02);
    rd_chk(ADDR_FLAGS, 8'h01);
    // enables under any guard or mode; only bits 7,4,1 exist
    for (int i = 0; i < 8; i++) begin
      rnd = 8'($urandom);
      write_guard_bit_i <= 1'($urandom);
      special_mode_i    <= 1'($urandom);
      wr(ADDR_ENABLE, rnd);
      rd_chk(ADDR_ENABLE, rnd & 8'h92);
    end
    // clock-select write permissions: guard, special, normal, after write-once
    sel_exp = RST_CLKSEL;
    for (int i = 0; i < 12; i++) begin
      rnd = 8'($urandom);
      write_guard_bit_i       <= (i % 4 == 0);
      special_mode_i          <= (i % 4 == 1);
      watchdog_written_once_i <= (i % 4 == 3);
      wr(ADDR_CLKSEL, rnd);
      sel_exp = sel_next(sel_exp, rnd, i % 4 == 0, i % 4 == 1, i % 4 == 3);
      rd_chk(ADDR_CLKSEL, sel_exp);
    end
    {write_guard_bit_i, special_mode_i, watchdog_written_once_i} <= 3'b000;
    // stall on oscillation loss only with monitor reset off
    wr(ADDR_CLKSEL, 8'h00);
    osc_loss_i <= 1'b1;
    wait_n(3);
    chk1(system_stall_o, 1'b1);
    // inputs move only on a rising edge, never between edges
    @(posedge ref_clk_i) osc_monitor_reset_enable_i <= 1'b1;
    wait_n(3);
    chk1(system_stall_o, 1'b0);
    @(posedge ref_clk_i) osc_loss_i <= 1'b0;
    // qualification loss: synth forced, lo cleared, hi kept, lo reopened once
    wr(ADDR_CLKSEL, 8'h11);
    watchdog_written_once_i <= 1'b1;
    @(posedge ref_clk_i) osc_good_i <= 1'b0;
    wait_n(3);
    chk8(clock_source_select_o, 8'h90);
    @(posedge ref_clk_i) osc_good_i <= 1'b1;
    wait_n(3);
    wr(ADDR_CLKSEL, 8'h91);
    rd_chk(ADDR_CLKSEL, 8'h91);
    wr(ADDR_CLKSEL, 8'h90);
    rd_chk(ADDR_CLKSEL, 8'h91);
    // full stop with the oscillator still good: lo cleared, synth forced
    wr(ADDR_CLKSEL, 8'h00);
    rd_chk(ADDR_CLKSEL, 8'h11);
    @(posedge ref_clk_i) full_stop_entry_i <= 1'b1;
    @(posedge ref_clk_i) full_stop_entry_i <= 1'b0;
    wait_n(2);
    chk8(clock_source_select_o, 8'h90);
    // synthesizer write drops lock and qualified, so both change flags rise
    @(posedge ref_clk_i) pll_lock_i <= 1'b1;
    wait_n(3);
    wr(ADDR_FLAGS, 8'h92);
    rd_chk(ADDR_FLAGS, 8'h09);
    rnd = 8'($urandom);
    wr(ADDR_SYNTH, rnd);
    rd_chk(ADDR_FLAGS, 8'h1b);
    rd_chk(ADDR_SYNTH, rnd);
    // unmapped place answers with an error and reads zero
    apb(1'b0, 12'hffc, 8'h00, rv, er);
    chk8(rv, 8'h00);
    chk1(er, 1'b1);
    summarize();
  end
endmodule : clock_unit_flags_and_select_bench
